/* logic/exc_pkg.sv */
package exc_pkg;

    localparam int VEC_W = 5;
    localparam int VEC_COUNT = 32;
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;
    localparam int EXT_LINES = 8;
    localparam int WAKE_PINS = 6;
    localparam int CAPT_SRCS = 5;
    localparam int CMP_SRCS = 3;
    localparam int SERIAL_SRCS = 4;

    // Vector numbers; priority falls as the number rises
    localparam logic [4:0] VEC_RESET = 5'h00;
    localparam logic [4:0] VEC_NMI = 5'h07;
    localparam logic [4:0] VEC_TRAP_BASE = 5'h08;
    localparam logic [4:0] VEC_TRAP_LAST = 5'h0B;
    localparam logic [4:0] VEC_ADDR_BREAK = 5'h0C;
    localparam logic [4:0] VEC_DIRECT = 5'h0D;
    localparam logic [4:0] VEC_LINE_A = 5'h0E;
    localparam logic [4:0] VEC_LINE_B = 5'h11;
    localparam logic [4:0] VEC_WAKEUP = 5'h12;
    localparam logic [4:0] VEC_CAPTURE_TIMER = 5'h15;
    localparam logic [4:0] VEC_COMPARE_TIMER = 5'h16;
    localparam logic [4:0] VEC_SERIAL = 5'h17;
    localparam logic [4:0] VEC_CONV_END = 5'h19;

    // Vectors 1 to 6 and 20
    localparam logic [31:0] RESERVED_MASK = 32'h0010007E;
    // Vectors 7 to 12: NMI, traps, address break
    localparam logic [31:0] UNMASKABLE_MASK = 32'h00001F80;

    // Line index within the external request group
    localparam int LINE_A_IDX = 0;
    localparam int LINE_B_IDX = 1;
    localparam int WAKE_BASE_IDX = 2;

    localparam logic EDGE_POL_RESET = 1'b0;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [15:0] HANDLER_RESET = 16'h0000;

    typedef enum logic [2:0] {
        ST_RESET_HOLD,
        ST_RUN,
        ST_FETCH_HI,
        ST_FETCH_LO,
        ST_BRANCH
    } exc_state_t;

    typedef struct packed {
        logic polarity;
        logic enable;
        logic clear;
    } ext_line_ctl_t;

    typedef struct packed {
        logic req;
        logic [15:0] addr;
    } vec_fetch_t;

    typedef struct packed {
        logic start;
        logic [4:0] num;
        logic [15:0] addr;
    } exc_info_t;

endpackage : exc_pkg

/* logic/ext_edge_flag.sv */
`timescale 1ns/100ps

module ext_edge_flag
    import exc_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic chip_reset_i,
    input wire logic line_i,
    input wire ext_line_ctl_t ctl_i,
    output logic flag_o,
    output logic request_o
);

    logic prev_reg;
    logic armed_reg;
    logic flag_reg;
    logic flag_next;
    wire logic edge_seen;

    // No edge is reported until one sample has been taken
    assign edge_seen = armed_reg
        & (ctl_i.polarity ? (line_i & ~prev_reg)
                          : (~line_i & prev_reg));
    // A new edge outweighs a software clear in the same cycle
    assign flag_next = edge_seen | (flag_reg & ~ctl_i.clear);

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i || chip_reset_i)
        begin
            prev_reg <= 1'b0;
            armed_reg <= 1'b0;
            flag_reg <= FLAG_RESET;
        end
        else
        begin
            prev_reg <= line_i;
            armed_reg <= 1'b1;
            flag_reg <= flag_next;
        end
    end

    assign flag_o = flag_reg;
    assign request_o = flag_reg & ctl_i.enable;

endmodule : ext_edge_flag

/* logic/vec_priority.sv */
`timescale 1ns/100ps

module vec_priority
    import exc_pkg::*;
(
    input wire logic [31:0] pending_i,
    output logic valid_o,
    output logic [4:0] vec_o
);

    // Lowest set vector number wins
    always_comb
    begin
        vec_o = VEC_RESET;
        for (int i = VEC_COUNT - 1; i >= 0; i--)
        begin
            if (pending_i[i])
            begin
                vec_o = 5'(i);
            end
        end
    end

    assign valid_o = |pending_i;

endmodule : vec_priority

/* logic/exception_vector_priority.sv */
// Functional notes
// - Reset outranks every source and uses vector 0 at address 0.
// - Reset processing starts when the reset pin rises, never while low.
// - Watchdog overflow acts as a pin reset, also using vector 0.
// - Trap number 0 to 3 selects vectors 8 to 11.
// - Traps are taken whenever the program runs, ignoring the mask bit.
// - Mask bit 1 blocks all interrupts except NMI and address break.
// - Interrupts start at instruction or exception-processing end only.
// - Several pending requests: lowest vector number is served first.
// - NMI 7, break 12, direct 13, lines 14 and 17, wakeup 18.
// - Capture timer 21, compare timer 22, serial 23, conversion end 25.
// - Vectors 1 to 6 and 20 stay reserved with no source.
// - Line edge: falling when polarity 0, rising when polarity 1.
// - A line request reaches arbitration only while its enable is 1.
// - An edge racing a flag clear is still taken; an enable clear drops the request at once.
`timescale 1ns/100ps

module exception_vector_priority
    import exc_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic external_reset_pin_n_i,
    input wire logic wdt_overflow_i,
    input wire logic instr_boundary_i,
    input wire logic software_trap_instruction_i,
    input wire logic [1:0] trap_number_i,
    input wire logic condition_code_register_mask_i,
    input wire logic nmi_req_i,
    input wire logic address_break_req_i,
    input wire logic direct_transition_req_i,
    input wire logic ext_request_line_a_i,
    input wire logic ext_request_line_b_i,
    input wire logic [5:0] shared_wakeup_pins_i,
    input wire logic line_a_edge_polarity_i,
    input wire logic line_a_request_enable_i,
    input wire logic line_b_edge_polarity_i,
    input wire logic line_b_request_enable_i,
    input wire logic [5:0] wakeup_edge_polarity_i,
    input wire logic wakeup_request_enable_i,
    input wire logic [7:0] ext_flag_clear_i,
    input wire logic [4:0] capture_timer_req_i,
    input wire logic [2:0] compare_timer_req_i,
    input wire logic [3:0] serial_unit_req_i,
    input wire logic conversion_end_req_i,
    input wire logic fetch_ack_i,
    input wire logic [7:0] fetch_data_i,
    output vec_fetch_t fetch_o,
    output exc_info_t exc_o,
    output logic [15:0] handler_addr_o,
    output logic branch_o,
    output logic busy_o,
    output logic chip_reset_o,
    output logic [7:0] ext_flags_o
);

    exc_state_t state_reg;
    exc_state_t state_next;
    logic [4:0] vec_reg;
    logic [4:0] vec_next;
    logic start_reg;
    logic start_next;
    logic [7:0] hi_reg;
    logic [7:0] hi_next;
    logic [15:0] handler_reg;
    logic [15:0] handler_next;
    logic branch_reg;
    logic branch_next;
    logic trap_pend_reg;
    logic trap_pend_next;
    logic [1:0] trap_num_reg;
    logic [1:0] trap_num_next;

    wire logic reset_cause;
    wire logic chip_reset;
    wire logic [7:0] line_level;
    wire logic [7:0] line_pol;
    wire logic [7:0] line_en;
    wire logic [7:0] line_req;
    wire logic [7:0] line_flag;
    wire logic wake_req;
    wire logic [4:0] trap_vec;
    wire logic [31:0] src_vec;
    wire logic [31:0] gate_mask;
    wire logic [31:0] pending;
    wire logic win_valid;
    wire logic [4:0] win_vec;
    wire logic take_point;
    wire logic take;
    wire logic trap_taken;
    wire logic [15:0] vec_addr;

    function automatic logic [31:0] onehot(input logic [4:0] v,
                                           input logic en);
        onehot = en ? (32'h00000001 << v) : 32'h00000000;
    endfunction : onehot

    // Chip reset: pin low or watchdog overflow, held in ST_RESET_HOLD
    assign reset_cause = ~external_reset_pin_n_i
        | wdt_overflow_i;
    assign chip_reset = (state_reg == ST_RESET_HOLD);

    // External lines: a, b, then the six wakeup pins
    assign line_level = {shared_wakeup_pins_i,
                         ext_request_line_b_i,
                         ext_request_line_a_i};
    assign line_pol = {wakeup_edge_polarity_i,
                       line_b_edge_polarity_i,
                       line_a_edge_polarity_i};
    assign line_en = {{WAKE_PINS{wakeup_request_enable_i}},
                      line_b_request_enable_i,
                      line_a_request_enable_i};

    genvar g;
    generate
        for (g = 0; g < EXT_LINES; g++)
        begin : g_line
            ext_edge_flag u_edge (
                .clk_i(clk_i),
                .nrst_i(nrst_i),
                .chip_reset_i(chip_reset),
                .line_i(line_level[g]),
                .ctl_i('{polarity: line_pol[g],
                         enable: line_en[g],
                         clear: ext_flag_clear_i[g]}),
                .flag_o(line_flag[g]),
                .request_o(line_req[g])
            );
        end
    endgenerate

    assign wake_req = |line_req[EXT_LINES-1:WAKE_BASE_IDX];

    assign trap_vec = VEC_TRAP_BASE + {3'b000, trap_num_reg};

    // Source map; several peripheral requests share one vector
    assign src_vec = onehot(VEC_NMI, nmi_req_i)
        | onehot(trap_vec, trap_pend_reg)
        | onehot(VEC_ADDR_BREAK, address_break_req_i)
        | onehot(VEC_DIRECT, direct_transition_req_i)
        | onehot(VEC_LINE_A, line_req[LINE_A_IDX])
        | onehot(VEC_LINE_B, line_req[LINE_B_IDX])
        | onehot(VEC_WAKEUP, wake_req)
        | onehot(VEC_CAPTURE_TIMER, |capture_timer_req_i)
        | onehot(VEC_COMPARE_TIMER, |compare_timer_req_i)
        | onehot(VEC_SERIAL, |serial_unit_req_i)
        | onehot(VEC_CONV_END, conversion_end_req_i);

    // Traps sit inside the unmaskable set
    assign gate_mask = condition_code_register_mask_i
        ? UNMASKABLE_MASK : 32'hFFFFFFFF;
    assign pending = src_vec & gate_mask & ~RESERVED_MASK;

    vec_priority u_prio (
        .pending_i(pending),
        .valid_o(win_valid),
        .vec_o(win_vec)
    );

    // End of an instruction, or end of exception processing
    assign take_point = (state_reg == ST_RUN && instr_boundary_i)
        || state_reg == ST_BRANCH;
    assign take = take_point && win_valid && !reset_cause;
    assign trap_taken = take && (win_vec >= VEC_TRAP_BASE)
        && (win_vec <= VEC_TRAP_LAST);

    // Vector table entry sits at twice the vector number
    assign vec_addr = {10'h000, vec_reg, 1'b0};

    always_comb
    begin
        state_next = state_reg;
        vec_next = vec_reg;
        start_next = 1'b0;
        hi_next = hi_reg;
        handler_next = handler_reg;
        branch_next = 1'b0;
        case (state_reg)
            ST_RESET_HOLD:
            begin
                // Sequence waits for the pin to rise
                if (!reset_cause)
                begin
                    state_next = ST_FETCH_HI;
                    vec_next = VEC_RESET;
                    start_next = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (take)
                begin
                    state_next = ST_FETCH_HI;
                    vec_next = win_vec;
                    start_next = 1'b1;
                end
            end
            ST_FETCH_HI:
            begin
                if (fetch_ack_i)
                begin
                    hi_next = fetch_data_i;
                    state_next = ST_FETCH_LO;
                end
            end
            ST_FETCH_LO:
            begin
                if (fetch_ack_i)
                begin
                    handler_next = {hi_reg, fetch_data_i};
                    branch_next = 1'b1;
                    state_next = ST_BRANCH;
                end
            end
            ST_BRANCH:
            begin
                // Chains straight into the next exception if one waits
                if (take)
                begin
                    state_next = ST_FETCH_HI;
                    vec_next = win_vec;
                    start_next = 1'b1;
                end
                else
                begin
                    state_next = ST_RUN;
                end
            end
            default:
            begin
                state_next = ST_RESET_HOLD;
            end
        endcase
        // Reset outranks everything, in any state
        if (reset_cause)
        begin
            state_next = ST_RESET_HOLD;
            start_next = 1'b0;
            branch_next = 1'b0;
        end
    end

    // Trap latch: a new trap in the take cycle is kept; its number
    // replaces the served one only after the vector was captured
    always_comb
    begin
        trap_pend_next = trap_pend_reg;
        trap_num_next = trap_num_reg;
        if (trap_taken)
        begin
            trap_pend_next = 1'b0;
        end
        if (software_trap_instruction_i && !chip_reset)
        begin
            trap_pend_next = 1'b1;
            trap_num_next = trap_number_i;
        end
        if (reset_cause)
        begin
            trap_pend_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= ST_RESET_HOLD;
            vec_reg <= VEC_RESET;
            start_reg <= 1'b0;
            hi_reg <= 8'h00;
            handler_reg <= HANDLER_RESET;
            branch_reg <= 1'b0;
            trap_pend_reg <= 1'b0;
            trap_num_reg <= 2'h0;
        end
        else
        begin
            state_reg <= state_next;
            vec_reg <= vec_next;
            start_reg <= start_next;
            hi_reg <= hi_next;
            handler_reg <= handler_next;
            branch_reg <= branch_next;
            trap_pend_reg <= trap_pend_next;
            trap_num_reg <= trap_num_next;
        end
    end

    assign fetch_o.req = (state_reg == ST_FETCH_HI)
        || (state_reg == ST_FETCH_LO);
    assign fetch_o.addr = (state_reg == ST_FETCH_LO)
        ? (vec_addr | 16'h0001) : vec_addr;
    assign exc_o.start = start_reg;
    assign exc_o.num = vec_reg;
    assign exc_o.addr = vec_addr;
    assign handler_addr_o = handler_reg;
    assign branch_o = branch_reg;
    assign busy_o = (state_reg != ST_RUN);
    assign chip_reset_o = chip_reset;
    assign ext_flags_o = line_flag;

endmodule : exception_vector_priority

/* bench/exc_asserts.sv */
`timescale 1ns/100ps
module exc_asserts
    import exc_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic external_reset_pin_n_i,
    input wire logic wdt_overflow_i,
    input wire logic instr_boundary_i,
    input wire logic condition_code_register_mask_i,
    input wire logic ext_request_line_a_i,
    input wire logic line_a_edge_polarity_i,
    input wire logic fetch_ack_i,
    input wire logic [7:0] fetch_data_i,
    input wire vec_fetch_t fetch_o,
    input wire exc_info_t exc_o,
    input wire logic [15:0] handler_addr_o,
    input wire logic branch_o,
    input wire logic chip_reset_o,
    input wire logic [7:0] ext_flags_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    // A reset cause aborts the fetch, so fetch rules pause
    wire run_ok = external_reset_pin_n_i && !wdt_overflow_i;
    property p_addr;
        $fell(chip_reset_o) |-> exc_o.start && exc_o.num == VEC_RESET
            && exc_o.addr == 16'h0000;
    endproperty
    a_addr: assert property (p_addr)
        else $error("reset did not start at vector 0");
    property p_pin;
        !external_reset_pin_n_i |=> chip_reset_o && !exc_o.start;
    endproperty
    a_pin: assert property (p_pin)
        else $error("processing while reset pin low");
    property p_wdt;
        wdt_overflow_i |=> chip_reset_o;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog did not reset chip");
    property p_rsv;
        exc_o.start |-> !RESERVED_MASK[exc_o.num];
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved vector taken");
    property p_mask;
        exc_o.start && exc_o.num != 5'h00
            && $past(condition_code_register_mask_i)
            |-> exc_o.num >= 5'h07 && exc_o.num <= 5'h0C;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked source taken");
    property p_bnd;
        exc_o.start && exc_o.num != 5'h00
            |-> $past(instr_boundary_i) || $past(branch_o);
    endproperty
    a_bnd: assert property (p_bnd)
        else $error("exception started mid instruction");
    property p_next;
        fetch_o.req && fetch_ack_i && !fetch_o.addr[0] && run_ok
            |=> fetch_o.req && fetch_o.addr == $past(fetch_o.addr) + 16'h0001;
    endproperty
    a_next: assert property (p_next)
        else $error("low byte not fetched next");
    property p_brn;
        fetch_o.req && fetch_ack_i && fetch_o.addr[0] && run_ok
            |=> branch_o && handler_addr_o[7:0] == $past(fetch_data_i);
    endproperty
    a_brn: assert property (p_brn)
        else $error("branch missing after low byte");
    property p_edge;
        run_ok && !chip_reset_o && $past(nrst_i) && !$past(chip_reset_o)
            && $changed(ext_request_line_a_i)
            && ext_request_line_a_i == line_a_edge_polarity_i
            && $stable(line_a_edge_polarity_i) |=> ext_flags_o[0];
    endproperty
    a_edge: assert property (p_edge)
        else $error("line a edge not flagged");
    c_nmi: cover property (exc_o.start && exc_o.num == 5'h07);
    c_chain: cover property (branch_o ##1 exc_o.start);
    c_rst: cover property ($fell(chip_reset_o));
endmodule : exc_asserts

/* bench/fetch_model.sv */
`timescale 1ns/100ps
module fetch_model
    import exc_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire vec_fetch_t fetch_i,
    input wire logic slow_i,
    output logic ack_o,
    output logic [7:0] data_o
);
    logic [1:0] wait_reg;
    wire go = fetch_i.req && !ack_o && wait_reg >= {slow_i, 1'b0};
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i || !go)
        begin
            ack_o <= 1'b0;
            // Idle bus flips so a stale byte never passes
            data_o <= ~data_o;
            wait_reg <= (nrst_i && fetch_i.req) ? wait_reg + 2'h1 : 2'h0;
        end
        else
        begin
            ack_o <= 1'b1;
            data_o <= fetch_i.addr[7:0] ^ 8'hA5;
            wait_reg <= 2'h0;
        end
    end
endmodule : fetch_model

/* bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top
    import exc_pkg::*;
;
    logic clk_i, nrst_i, external_reset_pin_n_i, wdt_overflow_i;
    logic instr_boundary_i, software_trap_instruction_i, slow;
    logic [1:0] trap_number_i;
    logic condition_code_register_mask_i, ext_request_line_a_i;
    logic ext_request_line_b_i, line_a_edge_polarity_i;
    logic line_a_request_enable_i, line_b_edge_polarity_i;
    logic line_b_request_enable_i, wakeup_request_enable_i;
    logic [5:0] shared_wakeup_pins_i, wakeup_edge_polarity_i;
    logic [7:0] ext_flag_clear_i, fetch_data_i, ext_flags_o;
    logic fetch_ack_i, branch_o, busy_o, chip_reset_o;
    logic [15:0] handler_addr_o;
    vec_fetch_t fetch_o;
    exc_info_t exc_o;
    logic [6:0] lv;
    wire nmi_req_i = lv[0];
    wire address_break_req_i = lv[1];
    wire direct_transition_req_i = lv[2];
    wire [4:0] capture_timer_req_i = {lv[3], 4'h0};
    wire [2:0] compare_timer_req_i = {2'h0, lv[4]};
    wire [3:0] serial_unit_req_i = {1'b0, lv[5], 2'h0};
    wire conversion_end_req_i = lv[6];
    logic [4:0] vt [7] = '{5'h07, 5'h0C, 5'h0D, 5'h15, 5'h16, 5'h17, 5'h19};
    int err_count = 0;
    int tests_run = 0;

    exception_vector_priority exception_vector_priority_i (.*);
    fetch_model fetch_model_i (.clk_i(clk_i), .nrst_i(nrst_i),
        .fetch_i(fetch_o), .slow_i(slow), .ack_o(fetch_ack_i),
        .data_o(fetch_data_i));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task report_and_stop();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task idle(input logic b);
        instr_boundary_i <= b;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk_i);
            if (i == 0)
                instr_boundary_i <= 1'b0;
            chk(16'(exc_o.start), 16'h0000);
        end
    endtask : idle

    // Clears flags and drops the served level so nothing retriggers
    task take(input logic [4:0] v, input logic b);
        int i;
        instr_boundary_i <= b;
        @(posedge clk_i);
        instr_boundary_i <= 1'b0;
        for (i = 0; i < 40 && exc_o.start !== 1'b1; i++)
            @(posedge clk_i);
        if (i == 40)
        begin
            err_count++;
            report_and_stop();
        end
        chk(16'(exc_o.num), 16'(v));
        chk(exc_o.addr, {10'h000, v, 1'b0});
        ext_flag_clear_i <= 8'hFF;
        for (int k = 0; k < 7; k++)
            if (vt[k] == v)
                lv[k] <= 1'b0;
        for (i = 0; i < 40 && branch_o !== 1'b1; i++)
            @(posedge clk_i);
        if (i == 40)
        begin
            err_count++;
            report_and_stop();
        end
        ext_flag_clear_i <= 8'h00;
        chk(handler_addr_o,
            {2'h0, v, 1'b0, 2'h0, v, 1'b1} ^ 16'hA5A5);
    endtask : take

    task s_mask();
        condition_code_register_mask_i <= 1'b1;
        lv <= 7'h40;
        idle(1'b1);
        chk(16'(busy_o), 16'h0000);
        lv[0] <= 1'b1;
        take(5'h07, 1'b1);
        condition_code_register_mask_i <= 1'b0;
        idle(1'b0);
        take(5'h19, 1'b1);
    endtask : s_mask

    task s_trap();
        condition_code_register_mask_i <= 1'b1;
        slow <= 1'b1;
        for (int n = 0; n < 4; n++)
        begin
            software_trap_instruction_i <= 1'b1;
            trap_number_i <= 2'(n);
            @(posedge clk_i);
            software_trap_instruction_i <= 1'b0;
            take(5'(8 + n), 1'b1);
        end
        condition_code_register_mask_i <= 1'b0;
        slow <= 1'b0;
    endtask : s_trap

    task s_line();
        line_a_request_enable_i <= 1'b0;
        ext_request_line_a_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        idle(1'b1);
        chk(16'(ext_flags_o), 16'h0001);
        line_a_request_enable_i <= 1'b1;
        take(5'h0E, 1'b1);
        ext_request_line_a_i <= 1'b1;
        line_b_edge_polarity_i <= 1'b1;
        ext_request_line_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(16'(ext_flags_o), 16'h0002);
        take(5'h11, 1'b1);
        shared_wakeup_pins_i <= 6'h37;
        repeat (2) @(posedge clk_i);
        chk(16'(ext_flags_o), 16'h0020);
        take(5'h12, 1'b1);
        // Edge and software clear in one cycle: the edge must survive
        @(posedge clk_i);
        ext_flag_clear_i <= 8'h01;
        ext_request_line_a_i <= 1'b0;
        @(posedge clk_i);
        ext_flag_clear_i <= 8'h00;
        @(posedge clk_i);
        chk(16'(ext_flags_o), 16'h0001);
        take(5'h0E, 1'b1);
    endtask : s_line

    initial
    begin
        {nrst_i, wdt_overflow_i, instr_boundary_i, trap_number_i, lv, slow,
            software_trap_instruction_i, condition_code_register_mask_i,
            ext_request_line_b_i, line_a_edge_polarity_i, ext_flag_clear_i,
            line_b_edge_polarity_i, wakeup_edge_polarity_i} = '0;
        {external_reset_pin_n_i, ext_request_line_a_i, shared_wakeup_pins_i,
            line_a_request_enable_i, line_b_request_enable_i,
            wakeup_request_enable_i} = '1;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        take(5'h00, 1'b0);
        lv <= 7'h7F;
        for (int k = 0; k < 7; k++)
            take(vt[k], k == 0);
        s_mask();
        s_trap();
        s_line();
        external_reset_pin_n_i <= 1'b0;
        idle(1'b0);
        chk(16'(chip_reset_o), 16'h0001);
        chk(16'(busy_o), 16'h0001);
        external_reset_pin_n_i <= 1'b1;
        take(5'h00, 1'b0);
        wdt_overflow_i <= 1'b1;
        @(posedge clk_i);
        wdt_overflow_i <= 1'b0;
        @(posedge clk_i);
        chk(16'(chip_reset_o), 16'h0001);
        take(5'h00, 1'b0);
        report_and_stop();
    end
endmodule : tb_top

bind exception_vector_priority exc_asserts exc_asserts_i (.*);
